//--- bzrf_regs.vh
// Functional notes
// - Sample rate from master select and rate
// - Cutoff code picks bypass, 4, 8, 16 Hz
// - Codes 0000-0011 give fast modulation frequencies
// - Codes 0100-1001 divide master; rest by 256
// - Unsupported cutoff runs 4 Hz, reads effective
// - Divider field bits 11:8, reset 1000
// - Magnitude bits 6:4, 000 floats drive
`ifndef BZRF_REGS_VH
`define BZRF_REGS_VH

// ==========================================================
// Register byte offsets
`define BZRF_OFS_GEN        8'h00
`define BZRF_OFS_IMP        8'h18
`define BZRF_OFS_STATUS     8'h1c
`define BZRF_OFS_RATE       8'h20
`define BZRF_OFS_FREQ       8'h24

// ==========================================================
// General config fields
`define BZRF_GEN_SEL_LSB    0
`define BZRF_GEN_RATE_BIT   2
`define BZRF_GEN_RESET      3'h0

// ==========================================================
// Impedance config fields
`define BZRF_IMP_CUT_LSB    12
`define BZRF_IMP_DIV_LSB    8
`define BZRF_IMP_MAG_LSB    4
`define BZRF_IMP_RESET      24'h201800

// ==========================================================
// Status fields
`define BZRF_ST_CUT_LSB     0
`define BZRF_ST_REMAP_BIT   2
`define BZRF_ST_MAGOK_BIT   3
`define BZRF_ST_FAST_BIT    4
`define BZRF_ST_DRIVE_BIT   5

// ==========================================================
// Master clock ticks per sample
`define BZRF_SMP_512        11'h200
`define BZRF_SMP_1024       11'h400
`define BZRF_SMP_640        11'h280
`define BZRF_SMP_1280       11'h500
`define BZRF_SMP_1230       11'h4ce

`endif

//--- bzrf_divider.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Divider counting master clock ticks
module bzrf_divider #(
  parameter W = 11
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         ce,
  input  wire         restart,
  input  wire         step,
  input  wire [W-1:0] period,
  output reg          tick,
  output reg          phase
);

  reg [W-1:0] count;            // Ticks seen in this period

  // Count steps, pulse and toggle at period end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {W{1'b0}};
      tick  <= 1'b0;
      phase <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (restart) begin
        // Realign so a new setting starts cleanly
        count <= {W{1'b0}};
        phase <= 1'b0;
      end else if (step) begin
        if (count >= period - {{(W-1){1'b0}}, 1'b1}) begin
          count <= {W{1'b0}};
          tick  <= 1'b1;
          phase <= ~phase;
        end else begin
          count <= count + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // bzrf_divider

`default_nettype wire

//--- bzrf_top.v
`timescale 1ns/1ps
`default_nettype none
`include "bzrf_regs.vh"

// ==========================================================
// Rate, cutoff and modulation configuration block
module bzrf_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        master_clk_pin,
  output wire        sample_tick,
  output reg         drive_p_out,
  output reg         drive_p_oe,
  output reg         drive_n_out,
  output reg         drive_n_oe,
  output reg  [2:0]  drive_magnitude_code,
  output reg  [1:0]  lowpass_cutoff_eff
);

  // ==========================================================
  // Table functions

  // Sample rate in hundredths of samples per second
  function [13:0] f_rate_centi;
    input [1:0] sel;
    input       rate;
    begin
      case ({sel, rate})
        3'h0:    f_rate_centi = 14'h1900;  // 64
        3'h1:    f_rate_centi = 14'h0c80;  // 32
        3'h2:    f_rate_centi = 14'h186a;  // 62.5
        3'h3:    f_rate_centi = 14'h0c35;  // 31.25
        3'h4:    f_rate_centi = 14'h1388;  // 50
        3'h5:    f_rate_centi = 14'h09c4;  // 25
        3'h6:    f_rate_centi = 14'h1383;  // 49.95
        default: f_rate_centi = 14'h0a26;  // 25.98
      endcase
    end
  endfunction

  // Master ticks per output sample
  function [10:0] f_smp_period;
    input [1:0] sel;
    input       rate;
    begin
      case ({sel, rate})
        3'h0, 3'h2: f_smp_period = `BZRF_SMP_512;
        3'h1, 3'h3: f_smp_period = `BZRF_SMP_1024;
        3'h4, 3'h6: f_smp_period = `BZRF_SMP_640;
        3'h5:       f_smp_period = `BZRF_SMP_1280;
        default:    f_smp_period = `BZRF_SMP_1230;
      endcase
    end
  endfunction

  // Code 11 only exists at the fast rate; fall back to 4 Hz
  function [1:0] f_eff_cut;
    input       rate;
    input [1:0] code;
    begin
      if (rate && (code == 2'h3))
        f_eff_cut = 2'h1;
      else
        f_eff_cut = code;
    end
  endfunction

  // Cutoff in millihertz, scaled with the master clock
  function [14:0] f_cut_mhz;
    input [1:0] sel;
    input [1:0] code;
    reg   [14:0] base;
    begin
      case (sel)
        2'h0:    base = 15'h1000;  // 4.096 Hz
        2'h3:    base = 15'h0f9c;  // 3.996 Hz
        default: base = 15'h0fa0;  // 4.000 Hz
      endcase
      case (code)
        2'h0:    f_cut_mhz = 15'h0000;     // Bypass
        2'h1:    f_cut_mhz = base;
        2'h2:    f_cut_mhz = base << 1;
        default: f_cut_mhz = base << 2;
      endcase
    end
  endfunction

  // Modulation frequency in hertz
  function [17:0] f_mod_hz;
    input [1:0] sel;
    input [3:0] code;
    reg   [17:0] fm;
    reg   [3:0]  k;
    begin
      case (sel)
        2'h0:    fm = 18'h08000;  // 32,768 Hz
        2'h3:    fm = 18'h07ce0;  // 31,968 Hz
        default: fm = 18'h07d00;  // 32,000 Hz
      endcase
      k = (code >= 4'ha) ? 4'h8 : (code - 4'h2);
      case (code)
        4'h0: f_mod_hz = (sel == 2'h0) ? 18'h20000 :
                         (sel == 2'h3) ? 18'h1f380 : 18'h1f400;
        4'h1: f_mod_hz = (sel == 2'h1 || sel == 2'h2) ? 18'h13880 : 18'h14000;
        4'h2: f_mod_hz = (sel == 2'h1 || sel == 2'h2) ? 18'h09c40 : 18'h0a000;
        4'h3: f_mod_hz = (sel == 2'h1 || sel == 2'h2) ? 18'h04574 : 18'h0471c;
        // Rounded shift of the master frequency
        default: f_mod_hz = (fm + ((18'h00001 << k) >> 1)) >> k;
      endcase
    end
  endfunction

  // Half period of the slow modulation, in master ticks
  function [7:0] f_mod_half;
    input [3:0] code;
    begin
      if (code >= 4'ha)
        f_mod_half = 8'h80;
      else
        f_mod_half = 8'h02 << (code - 4'h4);
    end
  endfunction

  // Whether software picked a legal magnitude for this divider
  function f_mag_ok;
    input [3:0] div;
    input [2:0] mag;
    begin
      if (div <= 4'h3)
        f_mag_ok = 1'b1;
      else if (div == 4'h4)
        f_mag_ok = (mag != 3'h7);
      else if (div == 4'h5)
        f_mag_ok = (mag <= 3'h3);
      else if (div == 4'h6)
        f_mag_ok = (mag <= 3'h2);
      else
        f_mag_ok = (mag <= 3'h1);
    end
  endfunction

  // ==========================================================
  // Register state
  reg  [2:0]  general_config_reg;    // Select and rate bit
  reg  [23:0] impedance_config_reg;  // Held exactly as written
  reg         cfg_restart;           // Realign dividers after a write

  wire [1:0] master_clock_select  = general_config_reg[`BZRF_GEN_SEL_LSB +: 2];
  wire       rate_bit             = general_config_reg[`BZRF_GEN_RATE_BIT];
  wire [1:0] lowpass_cutoff_code  = impedance_config_reg[`BZRF_IMP_CUT_LSB +: 2];
  wire [3:0] drive_modulation_divider = impedance_config_reg[`BZRF_IMP_DIV_LSB +: 4];
  wire [2:0] mag_field            = impedance_config_reg[`BZRF_IMP_MAG_LSB +: 3];

  wire [1:0]  eff_cut  = f_eff_cut(rate_bit, lowpass_cutoff_code);
  wire        remapped = (eff_cut != lowpass_cutoff_code);
  wire        mod_fast = (drive_modulation_divider <= 4'h3);
  wire        mag_ok   = f_mag_ok(drive_modulation_divider, mag_field);
  wire        drive_on = (mag_field != 3'h0);

  // ==========================================================
  // APB decode
  wire setup    = psel && !penable;
  wire access   = psel && penable;
  wire mapped   = (paddr == `BZRF_OFS_GEN) || (paddr == `BZRF_OFS_IMP) ||
                  (paddr == `BZRF_OFS_STATUS) || (paddr == `BZRF_OFS_RATE) ||
                  (paddr == `BZRF_OFS_FREQ);
  // Zero wait states; a frozen block holds the master off
  assign pready  = ce;
  assign pslverr = access && !mapped;
  wire   wr_take = access && ce && pwrite && mapped;

  // Effective cutoff replaces the stored one on read
  wire [23:0] imp_read = {impedance_config_reg[23:14], eff_cut,
                          impedance_config_reg[11:0]};

  // Write path and write side effects
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_config_reg   <= `BZRF_GEN_RESET;
      impedance_config_reg <= `BZRF_IMP_RESET;
      cfg_restart          <= 1'b0;
    end else if (ce) begin
      cfg_restart <= 1'b0;
      if (wr_take) begin
        if (paddr == `BZRF_OFS_GEN) begin
          general_config_reg <= pwdata[2:0];
          cfg_restart        <= 1'b1;
        end else if (paddr == `BZRF_OFS_IMP) begin
          // Raw value kept, remap applied only downstream
          impedance_config_reg <= pwdata[23:0];
          cfg_restart          <= 1'b1;
        end
      end
    end
  end

  // Read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce) begin
      if (setup && !pwrite) begin
        case (paddr)
          `BZRF_OFS_GEN:    prdata <= {29'h00000000, general_config_reg};
          `BZRF_OFS_IMP:    prdata <= {8'h00, imp_read};
          `BZRF_OFS_STATUS: prdata <= {26'h0000000, drive_on, mod_fast, mag_ok,
                                       remapped, eff_cut};
          `BZRF_OFS_RATE:   prdata <= {f_cut_mhz(master_clock_select, eff_cut), 3'h0,
                                       f_rate_centi(master_clock_select, rate_bit)};
          `BZRF_OFS_FREQ:   prdata <= {14'h0000,
                                       f_mod_hz(master_clock_select, drive_modulation_divider)};
          default:          prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Master clock pin synchroniser
  reg m_s1;    // First stage, read only by m_s2
  reg m_s2;
  reg m_s3;
  reg m_lvl;   // Accepted level

  // Three flops; a change counts once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_s1  <= 1'b0;
      m_s2  <= 1'b0;
      m_s3  <= 1'b0;
      m_lvl <= 1'b0;
    end else if (ce) begin
      m_s1 <= master_clk_pin;
      m_s2 <= m_s1;
      m_s3 <= m_s2;
      if (m_s2 == m_s3)
        m_lvl <= m_s3;
    end
  end

  wire master_rise = (m_s2 == m_s3) && m_s3 && !m_lvl;

  // ==========================================================
  // Sample rate and modulation dividers
  wire        mod_phase;
  wire [10:0] smp_period = f_smp_period(master_clock_select, rate_bit);
  wire [7:0]  mod_half   = f_mod_half(drive_modulation_divider);

  // One pulse per output sample
  bzrf_divider #(.W(11)) u_sample (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .restart (cfg_restart),
    .step    (master_rise),
    .period  (smp_period),
    .tick    (sample_tick),
    .phase   ()
  );

  // Slow modulation square wave; fast codes run off the analog side
  bzrf_divider #(.W(8)) u_mod (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .restart (cfg_restart || mod_fast),
    .step    (master_rise),
    .period  (mod_half),
    .tick    (),
    .phase   (mod_phase)
  );

  // ==========================================================
  // Drive outputs
  // Magnitude zero floats both drive pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_p_out          <= 1'b0;
      drive_n_out          <= 1'b0;
      drive_p_oe           <= 1'b0;
      drive_n_oe           <= 1'b0;
      drive_magnitude_code <= 3'h0;
      lowpass_cutoff_eff   <= 2'h1;
    end else if (ce) begin
      drive_p_oe           <= drive_on;
      drive_n_oe           <= drive_on;
      drive_p_out          <= drive_on && mod_phase;
      drive_n_out          <= drive_on && !mod_phase;
      drive_magnitude_code <= mag_field;
      lowpass_cutoff_eff   <= eff_cut;
    end
  end

endmodule // bzrf_top

`default_nettype wire

//--- bzrf_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker for the rate and modulation block
module bzrf_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sample_tick,
  input wire logic        drive_p_out,
  input wire logic        drive_p_oe,
  input wire logic        drive_n_out,
  input wire logic        drive_n_oe,
  input wire logic [2:0]  drive_magnitude_code
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Five words answer without error
  wire mapped = (paddr == 8'h00) || (paddr == 8'h18) || (paddr == 8'h1c) || (paddr == 8'h20) || (paddr == 8'h24);
  sequence s_access; psel && penable; endsequence
  sequence s_mag_off; (drive_magnitude_code == 3'h0)[*3]; endsequence
  sequence s_mag_on; (drive_magnitude_code != 3'h0)[*3]; endsequence
  sequence s_drive_on; drive_p_oe[*2]; endsequence
  // ==========================================================
  // Bus answer
  AST_PREADY_CE: assert property (pready == ce) else $error("pready differs from ce");
  AST_ERR_UNMAP: assert property (s_access ##0 !mapped |-> pslverr) else $error("no error on unmapped");
  AST_ERR_MAP: assert property (s_access ##0 mapped |-> !pslverr) else $error("error on mapped word");
  AST_ERR_IDLE: assert property (!(psel && penable) |-> !pslverr) else $error("error outside access");
  AST_RD_HOLD: assert property (!(psel && !penable && !pwrite && ce) |=> $stable(prdata))
    else $error("read data moved without read");
  // ==========================================================
  // Sample pulse and drive pins
  AST_TICK_PULSE: assert property (sample_tick |=> !sample_tick[*8]) else $error("sample pulse too long");
  AST_MAG_OFF: assert property (s_mag_off |-> !drive_p_oe && !drive_n_oe && !drive_p_out && !drive_n_out)
    else $error("drive active at zero magnitude");
  AST_MAG_ON: assert property (s_mag_on |-> drive_p_oe && drive_n_oe) else $error("drive not enabled");
  AST_DRV_COMP: assert property (s_drive_on |-> drive_p_out != drive_n_out) else $error("drive not complementary");
endmodule // bzrf_chk

bind bzrf_top bzrf_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
  .drive_p_out(drive_p_out), .drive_p_oe(drive_p_oe), .drive_n_out(drive_n_out), .drive_n_oe(drive_n_oe),
  .drive_magnitude_code(drive_magnitude_code));
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Register-level bench for the rate and modulation block
module testbench;
  logic        pclk, presetn, ce, psel, penable, pwrite, master_clk_pin, pin_run, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  logic [2:0]  pdiv;
  wire  [31:0] prdata;
  wire         pready, pslverr, sample_tick, drive_p_out, drive_p_oe, drive_n_out, drive_n_oe;
  wire  [2:0]  drive_magnitude_code;
  wire  [1:0]  lowpass_cutoff_eff;
  integer      miscompares = 0, n_tests = 0, i, rises = 0, r0;
  int          sr[8] = '{6400, 3200, 6250, 3125, 5000, 2500, 4995, 2598};
  int          c4[4] = '{4096, 4000, 4000, 3996};
  int          cf[4] = '{0, 4096, 8192, 16384};
  int          fq[16] = '{131072, 81920, 40960, 18204, 8192, 4096, 2048, 1024, 512, 256, 128, 128, 128, 128, 128, 128};
  // Divider, magnitude, legal: rows walk the edges of the allowed table
  int          mt[9][3] = '{'{4,7,0}, '{4,6,1}, '{5,4,0}, '{5,3,1}, '{6,3,0}, '{6,2,1}, '{7,2,0}, '{9,1,1}, '{0,7,1}};

  bzrf_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clk_pin(master_clk_pin), .sample_tick(sample_tick), .drive_p_out(drive_p_out),
    .drive_p_oe(drive_p_oe), .drive_n_out(drive_n_out), .drive_n_oe(drive_n_oe),
    .drive_magnitude_code(drive_magnitude_code), .lowpass_cutoff_eff(lowpass_cutoff_eff));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Fast stand-in master clock: ten bus cycles a period keeps the run short
  always @(posedge pclk) begin
    if (pin_run) begin
      pdiv <= (pdiv == 3'h4) ? 3'h0 : pdiv + 3'h1;
      if (pdiv == 3'h4) begin
        master_clk_pin <= ~master_clk_pin;
        if (!master_clk_pin) rises <= rises + 1;
      end
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One transfer; an idle cycle follows so the next setup is never a same-step reassign
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin miscompares++; final_report(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  function automatic logic [31:0] imp(input int cut, input int dv, input int mag);
    return 32'h200000 | (cut << 12) | (dv << 8) | (mag << 4);
  endfunction

  task automatic wait_tick;
    integer k;
    for (k = 0; k < 15000 && sample_tick !== 1'b1; k++) @(posedge pclk);
    if (k == 15000) begin miscompares++; final_report(); end
    @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    master_clk_pin = 1'b0; pin_run = 1'b0; pdiv = 3'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("impedance", 8'h18, imp(1, 8, 0));
    rdc("status", 8'h1c, 32'h9);
    rdc("freq", 8'h24, 32'd512);
    $display("test reset values done");
    // Every master select and rate at the 4 Hz cutoff
    for (i = 0; i < 8; i++) begin
      apb(1'b1, 8'h00, {29'h0, i[0], i[2:1]});
      rdc("rate", 8'h20, {c4[i/2][14:0], 3'h0, sr[i][13:0]});
    end
    $display("test sample rates done");
    apb(1'b1, 8'h00, 32'h0);
    for (i = 0; i < 16; i++) begin
      apb(1'b1, 8'h18, imp(1, i, 0));
      rdc("freq", 8'h24, fq[i]);
    end
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h18, imp(1, 0, 0));
    rdc("freq", 8'h24, 32'd127872);
    apb(1'b1, 8'h18, imp(1, 4, 0));
    rdc("freq", 8'h24, 32'd7992);
    $display("test modulation done");
    apb(1'b1, 8'h00, 32'h0);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 8'h18, imp(i, 8, 0));
      rdc("rate", 8'h20, {cf[i][14:0], 3'h0, 14'd6400});
    end
    apb(1'b1, 8'h00, 32'h4);
    rdc("impedance", 8'h18, imp(1, 8, 0));
    rdc("rate", 8'h20, {15'd4096, 3'h0, 14'd3200});
    rdc("status", 8'h1c, 32'hd);
    check("cutoff_eff", {30'h0, lowpass_cutoff_eff}, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
    rdc("impedance", 8'h18, imp(3, 8, 0));
    check("cutoff_eff", {30'h0, lowpass_cutoff_eff}, 32'h3);
    $display("test cutoff remap done");
    for (i = 0; i < 9; i++) begin
      apb(1'b1, 8'h18, imp(1, mt[i][0], mt[i][1]));
      rdc("status", 8'h1c, 32'h21 | (mt[i][2] << 3) | ((mt[i][0] < 4) ? 32'h10 : 32'h0));
      check("magnitude", {29'h0, drive_magnitude_code}, mt[i][1]);
      check("p_oe", {31'h0, drive_p_oe}, 32'h1);
    end
    apb(1'b1, 8'h18, imp(1, 8, 0));
    repeat (3) @(posedge pclk);
    check("n_oe", {31'h0, drive_n_oe}, 32'h0);
    $display("test magnitude done");
    apb(1'b1, 8'h1c, 32'hff);
    rdc("status", 8'h1c, 32'h9);
    apb(1'b0, 8'h04, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    // A frozen block must hold the bus master off
    ce <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    check("stall_ready", {31'h0, pready}, 32'h0);
    ce <= 1'b1;
    @(posedge pclk);
    rdc("status", 8'h1c, 32'h9);
    $display("test access kinds done");
    apb(1'b1, 8'h18, imp(1, 4, 1));
    pin_run <= 1'b1;
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 8'h00, (i == 0) ? 32'h0 : 32'h2);
      wait_tick();
      r0 = rises;
      wait_tick();
      check("ticks", rises - r0, (i == 0) ? 512 : 640);
      check("complement", {31'h0, drive_p_out ^ drive_n_out}, 32'h1);
    end
    $display("test sample pulse done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
